// ### rtl/mrb_consts.vh
// constants for the management register bank: addresses, bit positions, defaults, timing
`ifndef MRB_CONSTS_VH
`define MRB_CONSTS_VH

// register addresses (5-bit management address space)
`define MRB_A_CTRL      5'h00
`define MRB_A_STAT      5'h01
`define MRB_A_XCTL      5'h10
`define MRB_A_QSTAT     5'h11
`define MRB_A_GATE      5'h12

// control register bit positions
`define MRB_C_RST       15
`define MRB_C_LOOP      14
`define MRB_C_SPD       13
`define MRB_C_ANEN      12
`define MRB_C_LPWR      11
`define MRB_C_ISO       10
`define MRB_C_ANRS      9
`define MRB_C_DUP       8
`define MRB_C_COLT      7

// control register defaults
`define MRB_D_LOOP      1'b0
`define MRB_D_SPD       1'b1
`define MRB_D_ANEN      1'b1
`define MRB_D_LPWR      1'b0
`define MRB_D_DUP       1'b0
`define MRB_D_COLT      1'b0
`define MRB_D_TRIG      1'b0

// status register: latch-high and latch-low bit positions
`define MRB_S_JAB       1
`define MRB_S_LINK      2
`define MRB_S_RFLT      4
`define MRB_N_LH        2
`define MRB_D_LH        1'b0
`define MRB_D_LL        1'b1

// extended control register fields
`define MRB_X_OVR       15
`define MRB_X_PA_LSB    6
`define MRB_X_PA_MSB    10
`define MRB_X_TST_LSB   0
`define MRB_X_TST_MSB   3
`define MRB_D_OVR       1'b0
`define MRB_D_TST       4'h0
`define MRB_PA_ZERO     5'h00

// detailed status register fields
`define MRB_Q_MAX_LSB   11
`define MRB_Q_MAX_MSB   13
`define MRB_Q_W0        3
`define MRB_D_MAX       3'h0
`define MRB_D_W0        1'b0

// override-gated register field
`define MRB_G_LSB       0
`define MRB_G_MSB       7
`define MRB_D_GATE      8'h00

`define MRB_D_WORD      16'h0000

// timing
`define MRB_CLK_NS      40
`define MRB_SRST_NS     400

`endif

// ### rtl/mrb_sync2.v
// two-stage synchroniser for pin-level inputs
`timescale 1ns/10ps
module mrb_sync2 #(
  parameter WIDTH = 5
) (
  input  wire             clock,   // device clock
  input  wire [WIDTH-1:0] din,     // asynchronous level
  output reg  [WIDTH-1:0] dout     // synchronised level
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clock) begin
    meta_reg <= din;
    dout     <= meta_reg;
  end

endmodule

// ### rtl/mrb_bank.v
// management register bank with latching, self-clearing and gated bit types
//
// What this block does
// - every reset loads each register bit with its default; undefined bits carry none
// - pin-dependent defaults come from the pin level sampled during reset
// - a default is fixed zero, fixed one, pin-dependent, or absent
// - a latch-high bit goes to one as soon as its monitored signal asserts, except in the cycle that steps into low power
// - a set latch-high bit holds one until reset, a management read or the step into low power
// - after a read a latch-high bit reloads the live monitored level
// - a latch-low bit goes to zero as soon as its active-low signal asserts, except in the cycle that steps into low power
// - a cleared latch-low bit holds zero until reset, a management read or the step into low power
// - after a read a latch-low bit reloads the live monitored level
// - a running-max group keeps the largest value seen, updating only on larger
// - the running-max group holds until reset or read, then reloads current state
// - auto-clear trigger bits reset to zero and hold no lasting setting
// - writing one to an auto-clear trigger starts its function
// - when the function finishes its trigger returns to zero by itself
// - writes to read-only bits are ignored
// - override-gated bits take writes only with override set; override clears on the next write to any register but extended control
// - zero-only-write bits always read, and writes can only clear them
`timescale 1ns/10ps
`include "mrb_consts.vh"
module mrb_bank (
  input  wire        clock,           // 25 MHz device clock
  input  wire        reset,           // synchronous hardware reset, active high
  input  wire [4:0]  mgmt_addr,       // register address
  input  wire [15:0] mgmt_wdata,      // write data
  input  wire        mgmt_wr,         // one-cycle write strobe
  input  wire        mgmt_rd,         // one-cycle read strobe
  output reg  [15:0] mgmt_rdata,      // read data, valid with mgmt_rvalid
  output reg         mgmt_rvalid,     // one-cycle read answer
  output reg         mgmt_busy,       // software reset in progress, accesses ignored
  input  wire [4:0]  phy_addr_pin,    // address strap pins, asynchronous
  input  wire        link_ok,         // link status, low means link lost
  input  wire        jabber_det,      // jabber event, active high
  input  wire        remote_fault,    // remote fault event, active high
  input  wire [2:0]  train_state,     // monitored state machine value
  input  wire        fault_evt,       // hardware event setting the zero-only bit
  input  wire        an_restart_done, // restart function finished pulse
  output reg         loopback_en,     // loopback mode
  output reg         speed_100,       // data rate select
  output reg         an_enable,       // auto-negotiation enable
  output reg         low_power,       // low-power mode
  output reg         isolate,         // isolate from data interface
  output reg         full_duplex,     // duplex mode
  output reg         col_test,        // collision test
  output reg         an_restart,      // restart trigger, auto-clears
  output reg  [7:0]  gated_cfg,       // override-gated configuration
  output reg  [3:0]  test_bits,       // reserved test-mode bits
  output reg  [4:0]  phy_addr         // strapped device address
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SRST = 2'b10;

  // soft reset length, rounded up to whole cycles
  // fixed at build time: a different clock rate needs the timing macros changed
  localparam integer SRST_CYC_I = (`MRB_SRST_NS + `MRB_CLK_NS - 1) / `MRB_CLK_NS;
  localparam [7:0]   SRST_CYC   = SRST_CYC_I[7:0];

  wire [4:0]  pa_sync;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [7:0]  cnt_reg;
  reg  [7:0]  cnt_next;
  reg  [`MRB_N_LH-1:0] latch_high_event_bit;
  reg         latch_low_event_bit;
  reg  [2:0]  running_max_group;
  reg         zero_only_write;
  reg         override_reg;
  reg  [15:0] rd_mux;
  wire        init;
  wire        do_rd;
  wire        do_wr;
  wire        rd_stat;
  wire        rd_qstat;
  wire        wr_ctrl;
  wire        wr_xctl;
  wire        wr_qstat;
  wire        wr_gate;
  wire        srst_req;
  wire        lp_entry;
  wire [`MRB_N_LH-1:0] lh_mon;
  wire        wd_srst;
  wire        wd_lpwr;
  wire        wd_trig;
  wire        wd_ovr;
  wire        wd_zero;
  wire [3:0]  wd_test;
  wire [7:0]  wd_gate;

  mrb_sync2 #(.WIDTH(5)) u_pa_sync (
    .clock (clock),
    .din   (phy_addr_pin),
    .dout  (pa_sync)
  );

  // accesses during software reset are dropped so defaults are not disturbed
  assign init     = reset | state_reg[1];
  assign do_rd    = mgmt_rd & ~init;
  assign do_wr    = mgmt_wr & ~mgmt_rd & ~init;
  assign rd_stat  = do_rd & (mgmt_addr == `MRB_A_STAT);
  assign rd_qstat = do_rd & (mgmt_addr == `MRB_A_QSTAT);
  assign wr_ctrl  = do_wr & (mgmt_addr == `MRB_A_CTRL);
  assign wr_xctl  = do_wr & (mgmt_addr == `MRB_A_XCTL);
  assign wr_qstat = do_wr & (mgmt_addr == `MRB_A_QSTAT);
  assign wr_gate  = do_wr & (mgmt_addr == `MRB_A_GATE);
  assign srst_req = wr_ctrl & wd_srst;
  // only the step into low power re-arms the event bits, staying there does not
  assign lp_entry = wr_ctrl & wd_lpwr & ~low_power;
  assign lh_mon   = {remote_fault, jabber_det};

  // write-data fields named once, so each register block reads one meaning per bit
  assign wd_srst  = mgmt_wdata[`MRB_C_RST];
  assign wd_lpwr  = mgmt_wdata[`MRB_C_LPWR];
  assign wd_trig  = mgmt_wdata[`MRB_C_ANRS];
  assign wd_ovr   = mgmt_wdata[`MRB_X_OVR];
  assign wd_zero  = mgmt_wdata[`MRB_Q_W0];
  assign wd_test  = mgmt_wdata[`MRB_X_TST_MSB:`MRB_X_TST_LSB];
  assign wd_gate  = mgmt_wdata[`MRB_G_MSB:`MRB_G_LSB];

  // software reset sequencer
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (srst_req) begin
          state_next = ST_SRST;
          cnt_next   = SRST_CYC;
        end
      end
      ST_SRST: begin
        if (cnt_reg == 8'h01) begin
          state_next = ST_IDLE;
        end
        cnt_next = cnt_reg - 8'h01;
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = 8'h00;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 8'h00;
      mgmt_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      mgmt_busy <= state_next[1];
    end
  end

  // latch-high event bits, one per monitored signal
  genvar i;
  generate
    for (i = 0; i < `MRB_N_LH; i = i + 1) begin : g_lh
      always @(posedge clock) begin
        if (init) begin
          latch_high_event_bit[i] <= `MRB_D_LH;
        end else if (rd_stat) begin
          latch_high_event_bit[i] <= lh_mon[i];
        end else if (lp_entry) begin
          latch_high_event_bit[i] <= `MRB_D_LH;
        end else begin
          latch_high_event_bit[i] <= latch_high_event_bit[i] | lh_mon[i];
        end
      end
    end
  endgenerate

  // latch-low, running maximum and zero-only bits
  always @(posedge clock) begin
    if (init) begin
      latch_low_event_bit <= `MRB_D_LL;
      running_max_group   <= `MRB_D_MAX;
      zero_only_write     <= `MRB_D_W0;
    end else begin
      if (rd_stat) begin
        latch_low_event_bit <= link_ok;
      end else if (lp_entry) begin
        latch_low_event_bit <= `MRB_D_LL;
      end else begin
        latch_low_event_bit <= latch_low_event_bit & link_ok;
      end
      if (rd_qstat) begin
        running_max_group <= train_state;
      end else if (train_state > running_max_group) begin
        running_max_group <= train_state;
      end
      // a hardware event in the clearing cycle wins over the clear
      if (fault_evt) begin
        zero_only_write <= 1'b1;
      end else if (wr_qstat & ~wd_zero) begin
        zero_only_write <= 1'b0;
      end
    end
  end

  // writable control, override and configuration bits
  always @(posedge clock) begin
    if (init) begin
      loopback_en  <= `MRB_D_LOOP;
      speed_100    <= `MRB_D_SPD;
      an_enable    <= `MRB_D_ANEN;
      low_power    <= `MRB_D_LPWR;
      // an all-zero address strap keeps an unaddressed part off the data interface
      isolate      <= (pa_sync == `MRB_PA_ZERO);
      phy_addr     <= pa_sync;
      full_duplex  <= `MRB_D_DUP;
      col_test     <= `MRB_D_COLT;
      an_restart   <= `MRB_D_TRIG;
      override_reg <= `MRB_D_OVR;
      gated_cfg    <= `MRB_D_GATE;
      test_bits    <= `MRB_D_TST;
    end else begin
      if (wr_ctrl) begin
        loopback_en <= mgmt_wdata[`MRB_C_LOOP];
        speed_100   <= mgmt_wdata[`MRB_C_SPD];
        an_enable   <= mgmt_wdata[`MRB_C_ANEN];
        low_power   <= mgmt_wdata[`MRB_C_LPWR];
        isolate     <= mgmt_wdata[`MRB_C_ISO];
        full_duplex <= mgmt_wdata[`MRB_C_DUP];
        col_test    <= mgmt_wdata[`MRB_C_COLT];
      end
      // a fresh trigger in the done cycle starts the function again
      if (wr_ctrl & wd_trig) begin
        an_restart <= 1'b1;
      end else if (an_restart_done) begin
        an_restart <= 1'b0;
      end
      // override lasts until the next write of any register; an extended control write reloads it from its write data
      if (wr_xctl) begin
        override_reg <= wd_ovr;
        test_bits    <= wd_test;
      end else if (do_wr) begin
        override_reg <= 1'b0;
      end
      if (wr_gate & override_reg) begin
        gated_cfg <= wd_gate;
      end
    end
  end

  // read data assembly; read-only fields have no write path at all
  always @* begin
    rd_mux = `MRB_D_WORD;
    case (mgmt_addr)
      `MRB_A_CTRL: begin
        rd_mux[`MRB_C_RST]  = state_reg[1];
        rd_mux[`MRB_C_LOOP] = loopback_en;
        rd_mux[`MRB_C_SPD]  = speed_100;
        rd_mux[`MRB_C_ANEN] = an_enable;
        rd_mux[`MRB_C_LPWR] = low_power;
        rd_mux[`MRB_C_ISO]  = isolate;
        rd_mux[`MRB_C_ANRS] = an_restart;
        rd_mux[`MRB_C_DUP]  = full_duplex;
        rd_mux[`MRB_C_COLT] = col_test;
      end
      `MRB_A_STAT: begin
        rd_mux[`MRB_S_JAB]  = latch_high_event_bit[0];
        rd_mux[`MRB_S_RFLT] = latch_high_event_bit[1];
        rd_mux[`MRB_S_LINK] = latch_low_event_bit;
      end
      `MRB_A_XCTL: begin
        rd_mux[`MRB_X_OVR]                   = override_reg;
        rd_mux[`MRB_X_PA_MSB:`MRB_X_PA_LSB]   = phy_addr;
        rd_mux[`MRB_X_TST_MSB:`MRB_X_TST_LSB] = test_bits;
      end
      `MRB_A_QSTAT: begin
        rd_mux[`MRB_Q_MAX_MSB:`MRB_Q_MAX_LSB] = running_max_group;
        rd_mux[`MRB_Q_W0]                     = zero_only_write;
      end
      `MRB_A_GATE: begin
        rd_mux[`MRB_G_MSB:`MRB_G_LSB] = gated_cfg;
      end
      default: begin
        rd_mux = `MRB_D_WORD;
      end
    endcase
  end

  // read data captured on the same edge that reloads the latching bits
  always @(posedge clock) begin
    if (init) begin
      mgmt_rdata  <= `MRB_D_WORD;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= do_rd;
      if (do_rd) begin
        mgmt_rdata <= rd_mux;
      end
    end
  end

endmodule

// ### tb/mrb_sta_model.sv
// station manager model: issues register reads and writes
`timescale 1ns/10ps
module mrb_sta_model (
  input  wire         clock,       // device clock
  input  wire  [15:0] mgmt_rdata,  // read data
  input  wire         mgmt_rvalid, // read answer
  output logic [4:0]  mgmt_addr,   // register address
  output logic [15:0] mgmt_wdata,  // write data
  output logic        mgmt_wr,     // write strobe
  output logic        mgmt_rd      // read strobe
);
  initial begin
    mgmt_addr = 5'h1f;
    mgmt_wdata = 16'hffff;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
  end
  // released lines are inverted so a stale value never passes for a held one
  task wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    mgmt_addr = a;
    mgmt_wdata = (a == 5'h10) ? {d[15:4], 4'h0} : d;
    mgmt_wr = 1'b1;
    @(posedge clock);
    #1;
    mgmt_wr = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~mgmt_wdata;
  endtask
  task rd_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge clock);
    #1;
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(posedge clock);
    #1;
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
    ok = mgmt_rvalid;
    d = mgmt_rdata;
  endtask
endmodule

// ### tb/mrb_bank_checker.sv
// port assertions for the management register bank
`timescale 1ns/10ps
module mrb_bank_checker (
  input wire        clock,           // device clock
  input wire        reset,           // sync reset
  input wire [4:0]  mgmt_addr,       // address
  input wire [15:0] mgmt_wdata,      // write data
  input wire        mgmt_wr,         // write strobe
  input wire        mgmt_rd,         // read strobe
  input wire [15:0] mgmt_rdata,      // read data
  input wire        mgmt_rvalid,     // read answer
  input wire        mgmt_busy,       // soft reset busy
  input wire        jabber_det,      // latch-high source
  input wire        link_ok,         // latch-low source
  input wire [2:0]  train_state,     // max group source
  input wire        an_restart,      // trigger
  input wire        an_restart_done, // trigger finished
  input wire        loopback_en,     // ctrl bit
  input wire        speed_100        // ctrl bit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire rd_ok = mgmt_rd && !mgmt_wr && !mgmt_busy;
  wire rd_st = rd_ok && mgmt_addr == 5'h01;
  wire wr0   = mgmt_wr && !mgmt_rd && !mgmt_busy && mgmt_addr == 5'h00;
  property p_rv; rd_ok |=> mgmt_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_norv; !mgmt_rd |=> !mgmt_rvalid; endproperty
  a_norv: assert property (p_norv) else $error("answer without read");
  property p_lh; (jabber_det && !mgmt_wr && !mgmt_busy) ##1 rd_st |=> mgmt_rdata[1]; endproperty
  a_lh: assert property (p_lh) else $error("latch-high event lost");
  property p_ll; (!link_ok && !mgmt_wr && !mgmt_busy) ##1 rd_st |=> !mgmt_rdata[2]; endproperty
  a_ll: assert property (p_ll) else $error("latch-low event lost");
  property p_lhr;
    (rd_st && !jabber_det) ##1 (!jabber_det && !mgmt_wr && !mgmt_busy) ##1 rd_st
      |=> !mgmt_rdata[1];
  endproperty
  a_lhr: assert property (p_lhr) else $error("latch-high not reloaded");
  property p_max;
    (train_state == 3'h5 && !mgmt_busy) ##1 (rd_ok && mgmt_addr == 5'h11)
      |=> mgmt_rdata[13:11] >= 3'h5;
  endproperty
  a_max: assert property (p_max) else $error("maximum not held");
  property p_sc; wr0 && mgmt_wdata[9] && !mgmt_wdata[15] |=> an_restart; endproperty
  a_sc: assert property (p_sc) else $error("trigger not started");
  property p_scc; an_restart_done && !(mgmt_wr && mgmt_addr == 5'h00) |=> !an_restart; endproperty
  a_scc: assert property (p_scc) else $error("trigger not cleared");
  property p_busy; wr0 && mgmt_wdata[15] |=> ##1 mgmt_busy[*8]; endproperty
  a_busy: assert property (p_busy) else $error("soft reset too short");
  property p_dflt; $fell(mgmt_busy) |-> !loopback_en && speed_100 && !an_restart; endproperty
  a_dflt: assert property (p_dflt) else $error("defaults not loaded");
endmodule
bind mrb_bank mrb_bank_checker u_chk (.clock, .reset, .mgmt_addr, .mgmt_wdata, .mgmt_wr,
  .mgmt_rd, .mgmt_rdata, .mgmt_rvalid, .mgmt_busy, .jabber_det, .link_ok, .train_state,
  .an_restart, .an_restart_done, .loopback_en, .speed_100);

// ### tb/tb_top.sv
// self-checking bench for the management register bank
`timescale 1ns/10ps
`include "mrb_consts.vh"
module tb_top;
  logic        clock, reset, link_ok, jabber_det, remote_fault, fault_evt, an_restart_done;
  logic [4:0]  phy_addr_pin;
  logic [2:0]  train_state;
  wire  [4:0]  mgmt_addr, phy_addr;
  wire  [15:0] mgmt_wdata, mgmt_rdata;
  wire         mgmt_wr, mgmt_rd, mgmt_rvalid, mgmt_busy, loopback_en, speed_100, an_enable;
  wire         low_power, isolate, full_duplex, col_test, an_restart;
  wire  [7:0]  gated_cfg;
  wire  [3:0]  test_bits;
  int          n_mismatch, total_checks, cyc;
  mrb_bank dut (.clock, .reset, .mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata,
    .mgmt_rvalid, .mgmt_busy, .phy_addr_pin, .link_ok, .jabber_det, .remote_fault,
    .train_state, .fault_evt, .an_restart_done, .loopback_en, .speed_100, .an_enable,
    .low_power, .isolate, .full_duplex, .col_test, .an_restart, .gated_cfg, .test_bits,
    .phy_addr);
  mrb_sta_model m (.clock, .mgmt_rdata, .mgmt_rvalid, .mgmt_addr, .mgmt_wdata, .mgmt_wr,
    .mgmt_rd);
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task rdc(input logic [4:0] a, input logic [15:0] mk, input logic [15:0] exp, input string nm);
    logic [15:0] d;
    logic        ok;
    m.rd_reg(a, d, ok);
    chk("rvalid", 16'h0001, {15'h0, ok});
    chk(nm, exp, d & mk);
  endtask
  task t_defaults;
    rdc(`MRB_A_CTRL, 16'hffff, 16'h3000, "ctrl");
    chk("strap", 16'h000a, {11'h0, phy_addr});
    rdc(`MRB_A_XCTL, 16'h07c0, 16'h0280, "strap field");
    rdc(5'h05, 16'hffff, 16'h0000, "unmapped");
    chk("trigger", 16'h0000, {15'h0, an_restart});
    $display("defaults done");
  endtask
  task t_latch;
    jabber_det = 1'b1;
    remote_fault = 1'b1;
    link_ok = 1'b0;
    rdc(`MRB_A_STAT, 16'h0016, 16'h0012, "status history");
    jabber_det = 1'b0;
    remote_fault = 1'b0;
    link_ok = 1'b1;
    rdc(`MRB_A_STAT, 16'h0016, 16'h0012, "status reload");
    rdc(`MRB_A_STAT, 16'h0016, 16'h0004, "status live");
    $display("latch done");
  endtask
  task t_max;
    train_state = 3'h3;
    step(1);
    train_state = 3'h5;
    rdc(`MRB_A_QSTAT, 16'h3800, 16'h2800, "max");
    train_state = 3'h2;
    rdc(`MRB_A_QSTAT, 16'h3800, 16'h2800, "max kept");
    rdc(`MRB_A_QSTAT, 16'h3800, 16'h1000, "max live");
    $display("max done");
  endtask
  task t_misc;
    m.wr_reg(`MRB_A_CTRL, 16'h3200);
    chk("restart", 16'h0001, {15'h0, an_restart});
    step(3);
    an_restart_done = 1'b1;
    step(1);
    an_restart_done = 1'b0;
    rdc(`MRB_A_CTRL, 16'h0200, 16'h0000, "restart done");
    m.wr_reg(`MRB_A_GATE, 16'h005a);
    chk("gate shut", 16'h0000, {8'h0, gated_cfg});
    m.wr_reg(`MRB_A_XCTL, 16'h87cf);
    rdc(`MRB_A_XCTL, 16'h87cf, 16'h8280, "override");
    m.wr_reg(`MRB_A_GATE, 16'h005a);
    chk("gate open", 16'h005a, {8'h0, gated_cfg});
    m.wr_reg(`MRB_A_GATE, 16'h0033);
    chk("gate again", 16'h005a, {8'h0, gated_cfg});
    fault_evt = 1'b1;
    step(1);
    fault_evt = 1'b0;
    rdc(`MRB_A_QSTAT, 16'h0008, 16'h0008, "event set");
    m.wr_reg(`MRB_A_QSTAT, 16'h0000);
    rdc(`MRB_A_QSTAT, 16'h0008, 16'h0000, "write zero");
    m.wr_reg(`MRB_A_QSTAT, 16'h0008);
    rdc(`MRB_A_QSTAT, 16'h0008, 16'h0000, "write one");
    $display("misc done");
  endtask
  task t_lowpow;
    jabber_det = 1'b1;
    link_ok = 1'b0;
    step(1);
    jabber_det = 1'b0;
    link_ok = 1'b1;
    m.wr_reg(`MRB_A_CTRL, 16'h0d80);
    chk("pins a", 16'h0001, {12'h0, loopback_en, speed_100, an_enable, low_power});
    chk("pins b", 16'h0007, {13'h0, isolate, full_duplex, col_test});
    chk("test bits", 16'h0000, {12'h0, test_bits});
    rdc(`MRB_A_STAT, 16'h0016, 16'h0004, "status rearm");
    $display("low power done");
  endtask
  task t_soft;
    int i;
    phy_addr_pin = 5'h00;
    m.wr_reg(`MRB_A_CTRL, 16'h7000);
    chk("loopback", 16'h0001, {15'h0, loopback_en});
    m.wr_reg(`MRB_A_CTRL, 16'hc000);
    step(1);
    chk("busy", 16'h0001, {15'h0, mgmt_busy});
    for (i = 0; i < 20 && mgmt_busy === 1'b1; i++) step(1);
    chk("strap", 16'h0000, {11'h0, phy_addr});
    rdc(`MRB_A_CTRL, 16'hffff, 16'h3400, "ctrl");
    $display("soft reset done");
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    {reset, link_ok, jabber_det, remote_fault, fault_evt, an_restart_done} = 6'h30;
    phy_addr_pin = 5'h0a;
    train_state = 3'h0;
    {n_mismatch, total_checks} = 0;
    repeat (10) @(posedge clock);
    #1;
    reset = 1'b0;
    t_defaults;
    t_latch;
    t_max;
    t_misc;
    t_lowpow;
    t_soft;
    wrap_up;
  end
endmodule
